// ### core/wake_ctrl_pkg.sv
// Constants, types and register map for the standby wake-up controller.
package wake_ctrl_pkg;

	// -------------------------------------------------------------
	// Device register map
	// -------------------------------------------------------------
	localparam logic [31:0] CFG_A_ADDR = 32'hFFFF_EE10;
	localparam logic [31:0] CFG_B_ADDR = 32'hFFFF_EE14;
	localparam logic [31:0] CLR_ADDR   = 32'hFFFF_EE20;

	// -------------------------------------------------------------
	// Field layout of one byte lane of a configuration register
	// -------------------------------------------------------------
	localparam int          LANE_W    = 8;
	localparam int          LEVEL_LSB = 4;
	localparam int          EN_BIT    = 0;
	localparam int          CODE_W    = 3;
	localparam logic [1:0]  LVL_LOW   = 2'h0;
	localparam logic [1:0]  LVL_HIGH  = 2'h1;
	localparam logic [1:0]  LVL_FALL  = 2'h2;
	localparam logic [1:0]  LVL_RISE  = 2'h3;
	localparam logic [1:0]  LVL_RESET = LVL_FALL;

	// -------------------------------------------------------------
	// Source codes, shared by lane selection and request clearing
	// -------------------------------------------------------------
	localparam logic [2:0]  SRC_EXT4     = 3'h4;
	localparam logic [2:0]  SRC_KEYWAKE  = 3'h5;
	localparam logic [2:0]  SRC_EXTGROUP = 3'h6;
	localparam logic [2:0]  SRC_RTC      = 3'h7;

	// -------------------------------------------------------------
	// Commands, bus carrier and controller states
	// -------------------------------------------------------------
	typedef enum logic [1:0] {
		OP_CONFIG = 2'h0,
		OP_CLEAR  = 2'h1,
		OP_READ   = 2'h2
	} op_e;

	typedef struct packed {
		op_e        op;
		logic [2:0] src;
		logic [1:0] level;
		logic       enable;
	} cmd_s;

	typedef struct packed {
		logic [31:0] addr;
		logic [31:0] wdata;
		logic [3:0]  be;
		logic        wr;
		logic        rd;
	} dev_bus_s;

	typedef enum logic [8:0] {
		ST_IDLE   = 9'h001,
		ST_PIN    = 9'h002,
		ST_LEVEL  = 9'h004,
		ST_CLEAR  = 9'h008,
		ST_SIDE   = 9'h010,
		ST_ENABLE = 9'h020,
		ST_READ   = 9'h040,
		ST_BUS    = 9'h080,
		ST_DONE   = 9'h100
	} st_e;

endpackage

// ### core/sync2.sv
// Two flip-flop synchroniser for signals arriving from device pins.
`timescale 1ns/10ps
module sync2 #(
	parameter int W = 1
) (
	input  wire logic         clk_sys,
	input  wire logic         rst,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	logic [W-1:0] meta_r;

	// -------------------------------------------------------------
	// Synchroniser stages
	// -------------------------------------------------------------
	// The first stage feeds only the second stage.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			meta_r <= '0;
			q      <= '0;
		end else begin
			meta_r <= d;
			q      <= meta_r;
		end
	end

endmodule

// ### core/standby_wake_interrupt_ctrl.sv
// Controller that programs and clears the device's standby wake sources.
`timescale 1ns/10ps
// Function
// RULE1: Device has config register for inputs 0-3.
// RULE2: Two-bit field selects level or edge.
// RULE3: Bit 0 per lane enables the request.
// RULE4: Reset: fields read 10, enables 0.
// RULE5: Key wake and group fields set to 01.
// RULE6: Real-time clock field set to 11.
// RULE7: Enabling a source also programs its field.
// RULE8: Pin, level, clear, then enable, in order.
// RULE9: Eight sources can end standby.
// RULE10: Groups detect themselves; main controller high level.
// RULE11: Inputs 0-4 as plain interrupts: main level.
// RULE12: Groups as plain interrupts: own registers, high.
// RULE13: Clock interrupt configured in both blocks always.
// RULE14: Other sources have no wake fields.
// RULE15: Three-bit code clears one latched wake request.
// RULE16: Inputs and clock cleared twice, wake first.
// RULE17: Groups cleared through their own registers.
module standby_wake_interrupt_ctrl (
	input  wire logic                    clk_sys,
	input  wire logic                    rst,
	input  wire logic                    cmd_valid,
	input  wake_ctrl_pkg::cmd_s          cmd,
	output logic                         cmd_ready,
	output logic                         done,
	output logic [31:0]                  rd_data,
	output wake_ctrl_pkg::dev_bus_s      dev_bus,
	input  wire logic                    dev_ack,
	input  wire logic [31:0]             dev_rdata,
	output logic                         pin_enable,
	output logic                         main_cfg,
	output logic [1:0]                   main_level,
	output logic                         main_clear,
	output logic                         group_clear,
	output logic [2:0]                   side_src
);
	import wake_ctrl_pkg::*;

	st_e         state_r;
	st_e         state_nxt;
	st_e         ret_r;
	st_e         ret_nxt;
	logic        phase_r;
	logic        phase_nxt;
	cmd_s        cmd_r;
	dev_bus_s    bus_nxt;
	logic        ack_s;
	logic [31:0] rdata_s;
	logic        lvl_seen_r;
	logic        clr_seen_r;
	logic        mcfg_seen_r;

	// -------------------------------------------------------------
	// Pin synchronisers
	// -------------------------------------------------------------
	sync2 #(.W(1)) u_ack_sync (
		.clk_sys (clk_sys),
		.rst     (rst),
		.d       (dev_ack),
		.q       (ack_s)
	);

	sync2 #(.W(32)) u_rdata_sync (
		.clk_sys (clk_sys),
		.rst     (rst),
		.d       (dev_rdata),
		.q       (rdata_s)
	);

	// -------------------------------------------------------------
	// Source decode and lane data
	// -------------------------------------------------------------
	// Group sources detect their own edge, so the wake field is high.
	wire        grp_w    = (cmd_r.src == SRC_KEYWAKE) ||
	                       (cmd_r.src == SRC_EXTGROUP);
	wire        rtc_w    = (cmd_r.src == SRC_RTC);
	wire        pinsrc_w = (cmd_r.src <= SRC_EXT4);
	// Forced encodings for groups and the clock source.
	wire [1:0]  lvl_w    = grp_w ? LVL_HIGH : // RULE5 RULE10
	                       rtc_w ? LVL_RISE : // RULE6
	                       cmd_r.level;
	// Bit 2 of the code picks the register, the low bits the lane.
	wire [31:0] cfg_addr_w = cmd_r.src[2] ? CFG_B_ADDR : CFG_A_ADDR; // RULE1
	wire [3:0]  lane_be_w  = 4'(4'h1 << cmd_r.src[1:0]); // RULE9
	wire [7:0]  lane_lvl_w = 8'({6'h00, lvl_w} << LEVEL_LSB); // RULE2
	wire [7:0]  lane_off_w = lane_lvl_w;
	wire [7:0]  lane_on_w  = lane_lvl_w | 8'(8'h01 << EN_BIT); // RULE3
	wire [31:0] clr_data_w = {29'h0000_0000, cmd_r.src}; // RULE15
	wire        is_cfg_w   = (cmd_r.op == OP_CONFIG);
	wire        take_w     = (state_r == ST_IDLE) && cmd_valid;
	wire        ack_rd_w   = (state_r == ST_BUS) && !phase_r && ack_s &&
	                         dev_bus.rd;

	// -------------------------------------------------------------
	// Sequencer next state
	// -------------------------------------------------------------
	// Configuration walks pin (inputs 0-4 only), level, clear (not for groups), side, then enable if set.
	always_comb begin
		state_nxt = state_r;
		ret_nxt   = ret_r;
		phase_nxt = phase_r;
		bus_nxt   = dev_bus;
		unique case (state_r)
			ST_IDLE: begin
				if (cmd_valid) begin
					unique case (cmd.op)
						OP_CONFIG: state_nxt = (cmd.src <= SRC_EXT4) ?
						                       ST_PIN : ST_LEVEL;
						OP_CLEAR: state_nxt =
							((cmd.src == SRC_KEYWAKE) ||
							 (cmd.src == SRC_EXTGROUP)) ?
							ST_SIDE : ST_CLEAR;
						default: state_nxt = ST_READ;
					endcase
				end
			end
			ST_PIN: begin
				state_nxt = ST_LEVEL; // RULE8
			end
			ST_LEVEL: begin
				bus_nxt   = '{cfg_addr_w, {4{lane_off_w}}, lane_be_w,
				              1'b1, 1'b0}; // RULE7 RULE8
				ret_nxt   = grp_w ? ST_SIDE : ST_CLEAR;
				state_nxt = ST_BUS;
			end
			ST_CLEAR: begin
				bus_nxt   = '{CLR_ADDR, clr_data_w, 4'h1, 1'b1, 1'b0};
				ret_nxt   = ST_SIDE; // RULE16
				state_nxt = ST_BUS;
			end
			ST_SIDE: begin
				state_nxt = (is_cfg_w && cmd_r.enable) ? ST_ENABLE : ST_DONE;
			end
			ST_ENABLE: begin
				bus_nxt   = '{cfg_addr_w, {4{lane_on_w}}, lane_be_w,
				              1'b1, 1'b0}; // RULE8
				ret_nxt   = ST_DONE;
				state_nxt = ST_BUS;
			end
			ST_READ: begin
				bus_nxt   = '{cfg_addr_w, 32'h0000_0000, 4'hF, 1'b0, 1'b1};
				ret_nxt   = ST_DONE;
				state_nxt = ST_BUS;
			end
			ST_BUS: begin
				if (!phase_r) begin
					if (ack_s) begin
						bus_nxt.wr = 1'b0;
						bus_nxt.rd = 1'b0;
						phase_nxt  = 1'b1;
					end
				end else if (!ack_s) begin
					phase_nxt = 1'b0;
					state_nxt = ret_r;
				end
			end
			ST_DONE: begin
				state_nxt = ST_IDLE;
			end
		endcase
	end

	// -------------------------------------------------------------
	// Sequencer registers
	// -------------------------------------------------------------
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			state_r <= ST_IDLE;
			ret_r   <= ST_IDLE;
			phase_r <= 1'b0;
			dev_bus <= '0;
		end else begin
			state_r <= state_nxt;
			ret_r   <= ret_nxt;
			phase_r <= phase_nxt;
			dev_bus <= bus_nxt;
		end
	end

	// Command capture and read data return.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			cmd_r   <= '0;
			rd_data <= 32'h0000_0000;
		end else begin
			if (take_w) begin
				cmd_r <= cmd;
			end
			if (ack_rd_w) begin
				rd_data <= rdata_s;
			end
		end
	end

	// -------------------------------------------------------------
	// Side signals to pins, main controller and group blocks
	// -------------------------------------------------------------
	// Groups are cleared in their own blocks, the rest in main.
	wire side_w = (state_r == ST_SIDE);
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			cmd_ready   <= 1'b1;
			done        <= 1'b0;
			pin_enable  <= 1'b0;
			main_cfg    <= 1'b0;
			main_level  <= LVL_HIGH;
			main_clear  <= 1'b0;
			group_clear <= 1'b0;
			side_src    <= 3'h0;
		end else begin
			cmd_ready   <= (state_nxt == ST_IDLE);
			done        <= (state_r == ST_DONE);
			pin_enable  <= (state_r == ST_PIN) && pinsrc_w; // RULE8
			main_cfg    <= side_w && is_cfg_w; // RULE11 RULE13
			main_level  <= grp_w ? LVL_HIGH : cmd_r.level; // RULE10 RULE12
			main_clear  <= side_w && !grp_w; // RULE16
			group_clear <= side_w && grp_w; // RULE17
			side_src    <= cmd_r.src;
		end
	end

	// -------------------------------------------------------------
	// Helper flags for checking sequence order
	// -------------------------------------------------------------
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			lvl_seen_r  <= 1'b0;
			clr_seen_r  <= 1'b0;
			mcfg_seen_r <= 1'b0;
		end else if (state_r == ST_IDLE) begin
			lvl_seen_r  <= 1'b0;
			clr_seen_r  <= 1'b0;
			mcfg_seen_r <= 1'b0;
		end else begin
			lvl_seen_r  <= lvl_seen_r || (state_r == ST_LEVEL);
			clr_seen_r  <= clr_seen_r || (state_r == ST_CLEAR) || side_w;
			mcfg_seen_r <= mcfg_seen_r || (side_w && is_cfg_w);
		end
	end

	// -------------------------------------------------------------
	// Assertions and cover points
	// -------------------------------------------------------------
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);

	chk_keywake_field_high: assert property ( // RULE5
		dev_bus.wr && dev_bus.addr == CFG_B_ADDR && dev_bus.be[1] |->
		dev_bus.wdata[LANE_W + LEVEL_LSB +: 2] == LVL_HIGH)
		else $error("Key wake field not written as high level.");

	chk_rtc_field_rise: assert property ( // RULE6
		dev_bus.wr && dev_bus.addr == CFG_B_ADDR && dev_bus.be[3] |->
		dev_bus.wdata[3 * LANE_W + LEVEL_LSB +: 2] == LVL_RISE)
		else $error("Clock field not written as rising edge.");

	chk_enable_after_level: assert property ( // RULE7
		$rose(dev_bus.wr) && dev_bus.addr != CLR_ADDR &&
		dev_bus.wdata[EN_BIT] |-> lvl_seen_r)
		else $error("Enable written before the active state.");

	chk_enable_after_clear: assert property ( // RULE8
		$rose(dev_bus.wr) && dev_bus.addr != CLR_ADDR &&
		dev_bus.wdata[EN_BIT] |-> clr_seen_r && $past(main_clear ||
		group_clear, 2) == 1'b0 && !main_clear)
		else $error("Enable written before the request was cleared.");

	chk_group_main_high: assert property ( // RULE10
		main_cfg && (side_src == SRC_KEYWAKE || side_src == SRC_EXTGROUP)
		|-> main_level == LVL_HIGH)
		else $error("Group source not set high in main controller.");

	chk_config_main_done: assert property ( // RULE13
		$rose(done) && cmd_r.op == OP_CONFIG |-> $past(mcfg_seen_r))
		else $error("Configuration finished without main setting.");

	chk_wake_clear_first: assert property ( // RULE16
		$rose(main_clear) |-> $past(clr_seen_r) ##[1:64] done)
		else $error("Main clear not preceded by the wake clear.");

	chk_group_no_code: assert property ( // RULE17
		dev_bus.wr && dev_bus.addr == CLR_ADDR |->
		dev_bus.wdata[CODE_W-1:0] != SRC_KEYWAKE &&
		dev_bus.wdata[CODE_W-1:0] != SRC_EXTGROUP)
		else $error("Group request cleared through the wake register.");

	chk_req_held_ack: assert property ( // RULE15
		$fell(dev_bus.wr) |-> $past(ack_s) && state_r == ST_BUS)
		else $error("Device write dropped before acknowledge.");

	cov_config_rtc: cover property (
		$rose(done) && cmd_r.op == OP_CONFIG && cmd_r.src == SRC_RTC &&
		cmd_r.enable);
	cov_clear_ext: cover property (
		$rose(main_clear) ##[1:3] done);
	cov_group_clear: cover property ($rose(group_clear));
	cov_read_back: cover property (ack_rd_w ##[1:8] done);

endmodule

// ### tb/wake_dev_model.sv
// Behavioural model of the device's standby wake registers and handshake.
`timescale 1ns/10ps
module wake_dev_model (
	input  wire logic               clk_sys,
	input  wire logic               rst,
	input  wake_ctrl_pkg::dev_bus_s dev_bus,
	input  wire logic [3:0]         ack_delay,
	output logic                    dev_ack,
	output logic [31:0]             dev_rdata,
	output logic [31:0]             cfg_a_r,
	output logic [31:0]             cfg_b_r,
	output logic [2:0]              clr_code_r,
	output logic [7:0]              clr_cnt_r,
	output logic                    en_at_clr_r
);
	import wake_ctrl_pkg::*;
	logic [3:0]  wait_r;
	logic [31:0] rsel;
	logic [31:0] wmask;
	logic [31:0] wdat;
	logic        req;
	logic [63:0] both;

	// -------------------------------------------------------------
	// Decode
	// -------------------------------------------------------------
	// Eight lanes over two words; any other place reads as zero.
	assign req   = dev_bus.wr | dev_bus.rd;
	assign both  = {cfg_b_r, cfg_a_r};
	assign rsel  = (dev_bus.addr == CFG_A_ADDR) ? cfg_a_r :
	               (dev_bus.addr == CFG_B_ADDR) ? cfg_b_r : 32'h0;
	assign wmask = {{8{dev_bus.be[3]}}, {8{dev_bus.be[2]}},
	                {8{dev_bus.be[1]}}, {8{dev_bus.be[0]}}}
	               & 32'h3131_3131;
	assign wdat  = dev_bus.wdata & wmask;
	// Released data lines show the inverse so stale values cannot pass.
	assign dev_rdata = dev_ack ? rsel : ~rsel;

	// -------------------------------------------------------------
	// Four-phase handshake with a settable answer delay
	// -------------------------------------------------------------
	// The access takes effect at the edge that raises the acknowledge.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			cfg_a_r     <= 32'h2020_2020;
			cfg_b_r     <= 32'h2020_2020;
			dev_ack     <= 1'b0;
			wait_r      <= 4'h0;
			clr_code_r  <= 3'h0;
			clr_cnt_r   <= 8'h00;
			en_at_clr_r <= 1'b0;
		end else if (req && !dev_ack) begin
			if (wait_r != ack_delay) begin
				wait_r <= wait_r + 4'h1;
			end else begin
				dev_ack <= 1'b1;
				wait_r  <= 4'h0;
				if (dev_bus.wr && dev_bus.addr == CFG_A_ADDR) begin
					cfg_a_r <= (cfg_a_r & ~wmask) | wdat;
				end
				if (dev_bus.wr && dev_bus.addr == CFG_B_ADDR) begin
					cfg_b_r <= (cfg_b_r & ~wmask) | wdat;
				end
				if (dev_bus.wr && dev_bus.addr == CLR_ADDR) begin
					clr_code_r  <= dev_bus.wdata[2:0];
					clr_cnt_r   <= clr_cnt_r + 8'h01;
					en_at_clr_r <= both[{dev_bus.wdata[2:0], 3'h0}];
				end
			end
		end else if (!req) begin
			dev_ack <= 1'b0;
		end
	end
endmodule

// ### tb/tb_top.sv
// Self-checking bench for the standby wake-up controller.
`timescale 1ns/10ps
module tb_top;
	import wake_ctrl_pkg::*;
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin \
	num_errors++; $display("wrong value at %0t: %h %h", $time, a, b); \
	end end
	logic        clk_sys, rst, cmd_valid, cmd_ready, done, dev_ack;
	logic        pin_enable, main_cfg, main_clear, group_clear, en_at_clr;
	logic [1:0]  main_level, lvl_seen;
	logic [2:0]  side_src, clr_code, side_seen;
	logic [3:0]  ack_delay;
	logic [7:0]  clr_cnt;
	logic [31:0] rd_data, dev_rdata, cfg_a, cfg_b;
	logic [7:0]  exp_lane [8];
	cmd_s        cmd;
	dev_bus_s    dev_bus;
	int          num_errors, samples_checked;
	// Four-state counters, so an unknown pulse cannot pass as zero.
	integer      n_pin, n_cfg, n_mclr, n_gclr;

	standby_wake_interrupt_ctrl uut (.clk_sys(clk_sys), .rst(rst),
		.cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready),
		.done(done), .rd_data(rd_data), .dev_bus(dev_bus),
		.dev_ack(dev_ack), .dev_rdata(dev_rdata), .pin_enable(pin_enable),
		.main_cfg(main_cfg), .main_level(main_level),
		.main_clear(main_clear), .group_clear(group_clear),
		.side_src(side_src));
	wake_dev_model dev (.clk_sys(clk_sys), .rst(rst), .dev_bus(dev_bus),
		.ack_delay(ack_delay), .dev_ack(dev_ack), .dev_rdata(dev_rdata),
		.cfg_a_r(cfg_a), .cfg_b_r(cfg_b), .clr_code_r(clr_code),
		.clr_cnt_r(clr_cnt), .en_at_clr_r(en_at_clr));

	// Clock of 8 ns period.
	always #4 clk_sys = ~clk_sys;

	// Counts the side pulses of the command in flight, away from the
	// rising edge at which the pulses change.
	always @(negedge clk_sys) begin
		n_pin  += pin_enable;
		n_cfg  += main_cfg;
		n_mclr += main_clear;
		n_gclr += group_clear;
		if (main_cfg === 1'b1) begin
			lvl_seen = main_level;
			side_seen = side_src;
		end
	end

	// Expected lane byte; group and clock levels are fixed.
	function automatic logic [7:0] lane(input logic [2:0] s,
			input logic [1:0] l, input logic e);
		logic [1:0] v;
		v = (s == SRC_RTC) ? LVL_RISE : (s >= SRC_KEYWAKE) ? LVL_HIGH : l;
		return {2'h0, v, 3'h0, e};
	endfunction

	// Presents one command and waits for its completion pulse.
	task automatic send(input op_e op, input logic [2:0] s,
			input logic [1:0] l, input logic e);
		int n;
		n_pin = 0;
		n_cfg = 0;
		n_mclr = 0;
		n_gclr = 0;
		n = 0;
		@(posedge clk_sys);
		cmd_valid <= 1'b1;
		cmd <= '{op: op, src: s, level: l, enable: e};
		@(posedge clk_sys);
		while (cmd_ready !== 1'b1) @(posedge clk_sys);
		cmd_valid <= 1'b0;
		while (done !== 1'b1 && n < 3000) begin
			@(posedge clk_sys);
			n++;
		end
		`CHK(n < 3000, 1'b1)
	endtask

	// Checks how a request was cleared, by group or by both blocks.
	task automatic check_clear(input logic [2:0] s, input int c0);
		logic g;
		g = (s == SRC_KEYWAKE || s == SRC_EXTGROUP);
		`CHK(n_gclr, int'(g))
		`CHK(n_mclr, int'(!g))
		`CHK(int'(clr_cnt) - c0, int'(!g))
		if (!g) `CHK(clr_code, s)
	endtask

	// Reads both words back and compares with the expected lanes.
	task automatic check_regs();
		send(OP_READ, 3'h0, 2'h0, 1'b0);
		`CHK(rd_data, {exp_lane[3], exp_lane[2], exp_lane[1], exp_lane[0]})
		send(OP_READ, 3'h4, 2'h0, 1'b0);
		`CHK(rd_data, {exp_lane[7], exp_lane[6], exp_lane[5], exp_lane[4]})
	endtask

	// Configures one source and checks the bring-up sequence.
	task automatic configure(input logic [2:0] s, input logic [1:0] l,
			input logic e);
		int c0;
		c0 = int'(clr_cnt);
		send(OP_CONFIG, s, l, e);
		exp_lane[s] = lane(s, l, e);
		`CHK(n_pin, int'(s < 3'h5))
		`CHK(n_cfg, 1)
		`CHK(side_seen, s)
		`CHK(lvl_seen, (s >= SRC_KEYWAKE && s < SRC_RTC) ? LVL_HIGH : l)
		check_clear(s, c0);
		if (s >= SRC_KEYWAKE && s < SRC_RTC) `CHK(lvl_seen, LVL_HIGH)
		else `CHK(en_at_clr, 1'b0)
	endtask

	// Ends the run with the verdict.
	task automatic end_of_test();
		if (num_errors == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// Cuts a hang short.
	initial begin
		#160000;
		num_errors++;
		end_of_test();
	end

	// Main sequence.
	initial begin
		clk_sys = 1'b0;
		rst = 1'b1;
		cmd_valid = 1'b0;
		cmd = '0;
		ack_delay = 4'h0;
		lvl_seen = 2'h0;
		side_seen = 3'h0;
		num_errors = 0;
		samples_checked = 0;
		foreach (exp_lane[i]) exp_lane[i] = 8'h20;
		repeat (12) @(posedge clk_sys);
		rst <= 1'b0;
		check_regs();
		for (int d = 0; d < 2; d++) begin
			ack_delay <= 4'(d * 5);
			for (int s = 0; s < 8; s++) configure(3'(s), 2'(s + d), 1'b1);
			check_regs();
		end
		configure(3'h2, LVL_LOW, 1'b0);
		for (int s = 0; s < 8; s++) begin
			int c0;
			c0 = int'(clr_cnt);
			send(OP_CLEAR, 3'(s), 2'h0, 1'b0);
			check_clear(3'(s), c0);
		end
		check_regs();
		end_of_test();
	end
endmodule
